// file: dv/card_supply_config_regs_props.sv
// assertions on the register bank ports
// assumes one clock and async low reset
`timescale 1ns/100ps
module card_supply_config_regs_props (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // access and controls
    input card_supply_pkg::reg_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic voltage_good_in,
    input card_supply_pkg::conv_ctrl_t ctrl
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // converter and boost writes
    logic cw, bw;
    assign cw = req.wr && req.sel == card_supply_pkg::REG_CONV;
    assign bw = req.wr && req.sel == card_supply_pkg::REG_BOOST;
    sequence due_s;
        cw ##3 1'b1;
    endsequence
    read_ans_a: assert property (req.rd |=> rvalid) else $error("no answer");
    zero_bit_a: assert property (rvalid && $past(req.sel) == card_supply_pkg::REG_CONV |-> !rdata[4])
        else $error("bit4 set");
    conv_off_a: assert property (due_s |-> ctrl.conv_on == !$past(req.wdata[7], 3))
        else $error("conv_on wrong");
    deact_off_a: assert property (ctrl.deact_req |-> !ctrl.conv_on) else $error("deact on");
    no_deact_a: assert property (cw ##2 1'b1 |->
        ctrl.deact_req == ($past(req.wdata[7], 2) && $past(ctrl.conv_on, 1)))
        else $error("stray deact");
    step_en_a: assert property (due_s |-> ctrl.stepup_en == !$past(req.wdata[2], 3))
        else $error("stepup wrong");
    ovc_sel_a: assert property (due_s |-> ctrl.ovc_high == $past(req.wdata[3], 3))
        else $error("ovc wrong");
    vsel_map_a: assert property (due_s |-> ctrl.vsel == $past(req.wdata[1:0], 3))
        else $error("vsel wrong");
    boost_map_a: assert property (bw |=> ##2 ctrl.reg_boost == $past(req.wdata[7:4], 3))
        else $error("boost wrong");
endmodule
bind card_supply_config_regs card_supply_config_regs_props u_props (.clock(clock),
    .rst_n(rst_n), .req(req), .rdata(rdata), .rvalid(rvalid),
    .voltage_good_in(voltage_good_in), .ctrl(ctrl));

// file: dv/host_model.sv
// host link model driving the bank's access port
// assumes the bank shares clock
`timescale 1ns/100ps
module host_model (
    // clock
    input wire logic clock,
    // access port
    output card_supply_pkg::reg_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    // one access, strobe held for one edge, released data inverted
    task automatic xfer(input logic w, input logic [1:0] s, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge clock);
        req <= '{w, !w, card_supply_pkg::reg_sel_t'(s), d};
        @(posedge clock);
        req <= '{1'b0, 1'b0, card_supply_pkg::REG_NONE, ~d};
        #1 q = rvalid ? rdata : 8'hXX;
    endtask
    initial req = '0;
endmodule

// file: dv/testbench.sv
// self-checking bench for the register bank
// assumes host_model drives the access port
`timescale 1ns/100ps
module testbench;
    logic clock = 0, rst_n = 0, vgood = 0;
    card_supply_pkg::reg_req_t req;
    card_supply_pkg::conv_ctrl_t ctrl;
    logic [7:0] rdata, q, d, mc = 0;
    logic rvalid;
    int fail_count = 0, checked = 0, seed = 93;
    initial forever #4 clock = ~clock;
    card_supply_config_regs u_dut (.clock(clock), .rst_n(rst_n), .req(req), .rdata(rdata),
        .rvalid(rvalid), .voltage_good_in(vgood), .ctrl(ctrl));
    host_model u_host (.clock(clock), .req(req), .rdata(rdata), .rvalid(rvalid));
    // compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d fails %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // read one register and compare
    task automatic rchk(input logic [1:0] s, input logic [7:0] e);
        u_host.xfer(0, s, 8'h00, q);
        chk(q, e);
    endtask
    // write a register and wait until its controls land
    task automatic wr(input logic [1:0] s, input logic [7:0] v);
        u_host.xfer(1, s, v, q);
        repeat (1) @(posedge clock);
        #1;
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1;
        rchk(0, 8'h00);
        rchk(1, 8'h0F);
        rchk(3, 8'h00);
        repeat (20) begin
            d = $random(seed) & 8'hEF; // random off, adjust, step-up and select settings, bit four clear
            wr(0, d);
            chk({ctrl.conv_on, ctrl.deact_req, ctrl.stepup_en, ctrl.ovc_high, ctrl.vsel, 2'h0},
                {!d[7], d[7] && !mc[7], !d[2], d[3], d[1:0], 2'h0});
            mc = d & 8'h8F; // status bits six and five read back from hardware
            d = $random(seed) | 8'h0F;
            wr(1, d);
            chk({4'h0, ctrl.reg_boost}, d >> 4);
            u_host.xfer(1, 2, ~d, q);
            rchk(1, d);
            rchk(0, mc);
        end
        vgood <= 1;
        repeat (5) @(posedge clock);
        rchk(0, mc | 8'h60);
        rchk(0, mc | 8'h20);
        vgood <= 0;
        repeat (5) @(posedge clock);
        rchk(0, mc);
        wrap_up;
    end
    // hang guard
    initial begin
        #50000;
        fail_count++;
        wrap_up;
    end
endmodule

// file: logic/card_supply_config_regs.sv
// second converter configuration and regulator boost registers
// assumes the host link decoder presents single-cycle rd/wr strobes
// Functional notes
// R1: off bit stops converter, starts deactivation
// R2: off bit clear keeps converter enabled
// R3: event flag sets on voltage-good rising
// R4: reading converter register clears event flag
// R5: good bit mirrors synchronised voltage-good input
// R6: host waits for good before activation
// R7: host writes zero to bit four
// R8: adjust bit raises overcurrent threshold
// R9: step-up disable bit forces step-up off
// R10: host sets disable without inductor
// R11: select field decodes off, 2.2, 3.2, 5.2
// R12: select change never deactivates cards
// R13: host keeps voltage above active cards
// R14: deactivation leaves select field unchanged
// R15: converter register resets to zero
// R16: boost bits raise regulator currents
// R17: host keeps boost low bits at one
`timescale 1ns/100ps
module card_supply_config_regs (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register access
    input card_supply_pkg::reg_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    // analog status
    input wire logic voltage_good_in,
    // converter controls
    output card_supply_pkg::conv_ctrl_t ctrl
);
    logic good_s;
    logic good_d1_q;
    logic off_q;
    logic adj_q;
    logic stepup_dis_q;
    logic [1:0] vsel_q;
    logic event_q;
    logic [3:0] boost_q;
    logic [3:0] boost_low_q;
    logic off_prev_q;
    logic conv_rd;
    logic conv_wr;
    logic boost_wr;
    logic good_rise;

    sync2 u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .d(voltage_good_in),
        .q(good_s)
    );

    // access decode
    always_comb begin
        conv_rd = 1'b0;
        conv_wr = 1'b0;
        boost_wr = 1'b0;
        if (req.sel == card_supply_pkg::REG_CONV) begin
            conv_rd = req.rd;
            conv_wr = req.wr;
        end else if (req.sel == card_supply_pkg::REG_BOOST) begin
            boost_wr = req.wr;
        end
    end

    assign good_rise = good_s & ~good_d1_q;

    // writable converter fields; bit four is held zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            off_q <= card_supply_pkg::CONV_CFG_RESET[card_supply_pkg::OFF_BIT]; // [R15]
            adj_q <= card_supply_pkg::CONV_CFG_RESET[card_supply_pkg::ADJ_BIT];
            stepup_dis_q <= card_supply_pkg::CONV_CFG_RESET[card_supply_pkg::STEPUP_BIT];
            vsel_q <= card_supply_pkg::CONV_CFG_RESET[card_supply_pkg::SEL_HI:0];
        end else if (conv_wr) begin
            off_q <= req.wdata[card_supply_pkg::OFF_BIT];
            adj_q <= req.wdata[card_supply_pkg::ADJ_BIT];
            stepup_dis_q <= req.wdata[card_supply_pkg::STEPUP_BIT];
            // only the host changes the select field [R14]
            vsel_q <= req.wdata[card_supply_pkg::SEL_HI:card_supply_pkg::SEL_LO];
        end
    end

    // voltage event flag: set wins over read clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            good_d1_q <= 1'b0;
            event_q <= 1'b0;
        end else begin
            good_d1_q <= good_s;
            if (good_rise) begin
                event_q <= 1'b1; // [R3]
            end else if (conv_rd) begin
                event_q <= 1'b0; // [R4]
            end
        end
    end

    // regulator boost register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            boost_q <= card_supply_pkg::BOOST_RESET[7:card_supply_pkg::BOOST_LO];
            boost_low_q <= card_supply_pkg::BOOST_RESET[3:0];
        end else if (boost_wr) begin
            boost_q <= req.wdata[7:card_supply_pkg::BOOST_LO];
            boost_low_q <= req.wdata[3:0]; // stored as written, host keeps ones
        end
    end

    // read data and valid, registered
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            if (conv_rd) begin
                rdata <= {off_q, event_q, good_s, 1'b0, adj_q, stepup_dis_q, vsel_q}; // [R5]
            end else if (req.rd && req.sel == card_supply_pkg::REG_BOOST) begin
                rdata <= {boost_q, boost_low_q};
            end else if (req.rd) begin
                rdata <= 8'h00;
            end
        end
    end

    // converter controls; deactivation pulses on off-bit rise only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            off_prev_q <= 1'b0;
            ctrl <= '0;
        end else begin
            off_prev_q <= off_q;
            ctrl.conv_on <= ~off_q; // [R1] [R2]
            ctrl.deact_req <= off_q & ~off_prev_q; // [R1] [R12]
            ctrl.stepup_en <= ~stepup_dis_q; // [R9]
            ctrl.ovc_high <= adj_q; // [R8]
            ctrl.vsel <= card_supply_pkg::vsel_t'(vsel_q); // [R11]
            ctrl.reg_boost <= boost_q; // [R16]
        end
    end
endmodule

// file: logic/card_supply_pkg.sv
// card supply register bank: shared constants and carrier types
// assumes an 8-bit register access port provided by the host link decoder
package card_supply_pkg;
    localparam logic [7:0] CONV_CFG_RESET = 8'h00;
    localparam logic [7:0] BOOST_RESET = 8'h0F;
    localparam int OFF_BIT = 7;
    localparam int EVENT_BIT = 6;
    localparam int GOOD_BIT = 5;
    localparam int ZERO_BIT = 4;
    localparam int ADJ_BIT = 3;
    localparam int STEPUP_BIT = 2;
    localparam int SEL_HI = 1;
    localparam int SEL_LO = 0;
    localparam int BOOST_LO = 4;
    localparam int NUM_REG = 4;

    // voltage select codes
    typedef enum logic [1:0] {
        VSEL_OFF = 2'h0,
        VSEL_2V2 = 2'h1,
        VSEL_3V2 = 2'h2,
        VSEL_5V2 = 2'h3
    } vsel_t;

    // register selector on the access port
    typedef enum logic [1:0] {
        REG_CONV = 2'h0,
        REG_BOOST = 2'h1,
        REG_NONE = 2'h2
    } reg_sel_t;

    // access request from the host link
    typedef struct packed {
        logic wr;
        logic rd;
        reg_sel_t sel;
        logic [7:0] wdata;
    } reg_req_t;

    // converter controls to the analog side
    typedef struct packed {
        logic conv_on;
        logic deact_req;
        logic stepup_en;
        logic ovc_high;
        vsel_t vsel;
        logic [NUM_REG-1:0] reg_boost;
    } conv_ctrl_t;
endpackage

// file: logic/sync2.sv
// two-flop synchroniser for the analog voltage-good level
// assumes the input is asynchronous to clock
`timescale 1ns/100ps
module sync2 (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // level in and out
    input wire logic d,
    output logic q
);
    logic meta_q;

    // first flop read only by the second
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule
